// ---- rtl/frame_delay_line.sv ----
`timescale 1ns/10ps
// fixed-length shift delay for one flag bit
module frame_delay_line #(
  parameter int DEPTH = 8
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic shift_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic [DEPTH-1:0] taps;

  // advance only on frame strobes so depth counts frames
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      taps <= '0;
    end else if (shift_i) begin
      taps <= {taps[DEPTH-2:0], d_i};
    end
  end

  assign q_o = taps[DEPTH-1];
endmodule

// ---- rtl/sample_timing_core.sv ----
`timescale 1ns/10ps
// Function
// RULE_01: sample clock is input clock divided by 1, 2, 4 or 8.
// RULE_02: frame clock equals sample clock; frame delays count samples.
// RULE_03: reference sample meets lmfc boundary 12.5 frames after sampling; the code rounds this up to 13 frames.
// RULE_04: over-range flag asserts 7.5 frames after an over-range sample; the code rounds this up to 8 frames.
// RULE_05: flag releases after first in-range sample plus 0..15 extension frames.
// RULE_06: source holds sysref high at least 2 frames after rising.
// RULE_07: source holds sysref low at least 2 frames after falling.
// RULE_08: lmfc boundary 3.5/8/15/29 input cycles after sysref latch; the code waits 4 cycles instead of 3.5 at ratio 1.
// RULE_09: sysref rising edge sampled on clock restarts the lmfc counter.
module sample_timing_core
  import sample_timing_pkg::*;
#(
  parameter int LMFC_LEN = sample_timing_pkg::LMFC_FRAMES
) (
  input  wire logic                                   sys_clk_i,
  input  wire logic                                   rst_n_i,
  input  wire logic [1:0]                             sample_clock_divide_ratio_i,
  input  wire logic [sample_timing_pkg::OVR_EXT_W-1:0] ovr_release_ext_i,
  input  wire logic                                   sysref_i,
  input  wire logic                                   over_a_i,
  input  wire logic                                   over_b_i,
  output logic                                        sample_strobe_o,
  output logic                                        lmfc_boundary_o,
  output logic                                        ref_sample_o,
  output logic                                        overrange_flag_chan_a_o,
  output logic                                        overrange_flag_chan_b_o
);
  import sample_timing_pkg::*;

  // sys_clk_i stands for the input clock; the half-cycle offsets become
  // integer frame counts by rounding the .5 up (one extra cycle).
  localparam int OVR_ASSERT_CYC = (OVR_ASSERT_HALF + 1) / 2;
  localparam int LAT_CORE_CYC   = (LAT_CORE_HALF + 1) / 2;

  logic [DIV_CNT_W-1:0]  div_cnt;
  logic [DIV_CNT_W-1:0]  div_last;
  logic                  frame_tick;
  logic                  sysref_q;
  logic                  sysref_rise;
  logic [6:0]            sys_wait;
  logic                  sys_pending;
  logic [6:0]            sys_delay;
  logic [LMFC_CNT_W-1:0] lmfc_cnt;
  logic [7:0]            lat_cnt;
  logic                  lat_busy;

  // RULE_01 ratio decode
  always_comb begin
    case (sample_clock_divide_ratio_i)
      DIV_SEL_1: div_last = DIV_CNT_W'(0);
      DIV_SEL_2: div_last = DIV_CNT_W'(1);
      DIV_SEL_4: div_last = DIV_CNT_W'(3);
      DIV_SEL_8: div_last = DIV_CNT_W'(DIV_MAX - 1);
      default:   div_last = DIV_CNT_W'(0);
    endcase
  end

  // RULE_08 sysref delay per ratio, rounded up to whole input cycles
  always_comb begin
    case (sample_clock_divide_ratio_i)
      DIV_SEL_1: sys_delay = 7'((SYS_LMFC_HALF_1 + 1) / 2);
      DIV_SEL_2: sys_delay = 7'(SYS_LMFC_HALF_2 / 2);
      DIV_SEL_4: sys_delay = 7'(SYS_LMFC_HALF_4 / 2);
      DIV_SEL_8: sys_delay = 7'(SYS_LMFC_HALF_8 / 2);
      default:   sys_delay = 7'((SYS_LMFC_HALF_1 + 1) / 2);
    endcase
  end

  // RULE_01 divider; a sysref restart realigns the phase too
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      div_cnt <= '0;
    end else if (sys_pending && sys_wait == 7'h01) begin
      div_cnt <= '0;
    end else if (div_cnt >= div_last) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + DIV_CNT_W'(1);
    end
  end

  assign frame_tick = (div_cnt == '0);

  // RULE_02 frame strobe is the sample strobe
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sample_strobe_o <= 1'b0;
    end else begin
      sample_strobe_o <= frame_tick;
    end
  end

  // RULE_09 edge detect on sampled sysref
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sysref_q <= 1'b0;
    end else begin
      sysref_q <= sysref_i;
    end
  end

  assign sysref_rise = sysref_i && !sysref_q;

  // RULE_08 countdown from sysref latch to forced boundary
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sys_pending <= 1'b0;
      sys_wait    <= '0;
    end else if (sysref_rise) begin
      sys_pending <= 1'b1;
      sys_wait    <= sys_delay;
    end else if (sys_pending) begin
      sys_wait    <= sys_wait - 7'h01;
      sys_pending <= (sys_wait != 7'h01);
    end
  end

  // RULE_09 lmfc counter restart; wraps every LMFC_LEN frames
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      lmfc_cnt        <= '0;
      lmfc_boundary_o <= 1'b0;
    end else if (sys_pending && sys_wait == 7'h01) begin
      lmfc_cnt        <= LMFC_CNT_W'(1);
      lmfc_boundary_o <= 1'b1;
    end else if (frame_tick) begin
      lmfc_cnt        <= (32'(lmfc_cnt) == LMFC_LEN - 1) ? '0 : lmfc_cnt + LMFC_CNT_W'(1);
      lmfc_boundary_o <= (lmfc_cnt == '0);
    end else begin
      lmfc_boundary_o <= 1'b0;
    end
  end

  // RULE_03 reference sample marker: count core latency in frames from each
  // lmfc boundary output; busy guard keeps one marker per multiframe
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      lat_cnt      <= '0;
      lat_busy     <= 1'b0;
      ref_sample_o <= 1'b0;
    end else if (lmfc_boundary_o) begin
      lat_busy     <= 1'b1;
      // a frame tick on the load cycle already counts as one frame
      lat_cnt      <= frame_tick ? 8'(LAT_CORE_CYC - 1) : 8'(LAT_CORE_CYC);
      ref_sample_o <= 1'b0;
    end else if (lat_busy && frame_tick) begin
      lat_cnt      <= lat_cnt - 8'h01;
      ref_sample_o <= (lat_cnt == 8'h01);
      lat_busy     <= (lat_cnt != 8'h01);
    end else begin
      ref_sample_o <= 1'b0;
    end
  end

  // RULE_04 fixed assertion delay in frames for both channels
  logic dly_a;
  logic dly_b;

  frame_delay_line #(.DEPTH(OVR_ASSERT_CYC)) u_dly_a (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .shift_i   (frame_tick),
    .d_i       (over_a_i),
    .q_o       (dly_a)
  );

  frame_delay_line #(.DEPTH(OVR_ASSERT_CYC)) u_dly_b (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .shift_i   (frame_tick),
    .d_i       (over_b_i),
    .q_o       (dly_b)
  );

  // RULE_05 release hold per channel: reload on each delayed over-range
  logic [OVR_EXT_W-1:0] hold_a;
  logic [OVR_EXT_W-1:0] hold_b;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      hold_a                  <= '0;
      overrange_flag_chan_a_o <= 1'b0;
    end else if (frame_tick) begin
      if (dly_a) begin
        hold_a                  <= ovr_release_ext_i;
        overrange_flag_chan_a_o <= 1'b1;
      end else if (hold_a != '0) begin
        hold_a <= hold_a - OVR_EXT_W'(1);
      end else begin
        overrange_flag_chan_a_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      hold_b                  <= '0;
      overrange_flag_chan_b_o <= 1'b0;
    end else if (frame_tick) begin
      if (dly_b) begin
        hold_b                  <= ovr_release_ext_i;
        overrange_flag_chan_b_o <= 1'b1;
      end else if (hold_b != '0) begin
        hold_b <= hold_b - OVR_EXT_W'(1);
      end else begin
        overrange_flag_chan_b_o <= 1'b0;
      end
    end
  end

  // checks
  sequence s_sys_edge;
    sysref_rise && !sys_pending;
  endsequence

  // RULE_08 lmfc boundary after sysref in ratio 1
  property p_sys_lmfc;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (s_sys_edge and (sample_clock_divide_ratio_i == DIV_SEL_1)) ##1
      (sample_clock_divide_ratio_i == DIV_SEL_1)[*3] |-> ##2 lmfc_boundary_o;
  endproperty
  a_sys_lmfc: assert property (p_sys_lmfc) else $error("lmfc not placed after sysref"); // RULE_08

  // RULE_09 sysref edge arms the countdown
  property p_sys_arm;
    @(posedge sys_clk_i) disable iff (!rst_n_i) sysref_rise |=> sys_pending;
  endproperty
  a_sys_arm: assert property (p_sys_arm) else $error("sysref edge not taken"); // RULE_09

  // RULE_01 divide by 8 gives frame ticks 8 apart
  property p_div8;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (frame_tick && sample_clock_divide_ratio_i == DIV_SEL_8 && !sys_pending)
      |=> !frame_tick [*7];
  endproperty
  a_div8: assert property (p_div8) else $error("divide by 8 spacing wrong"); // RULE_01

  // RULE_02 sample strobe follows frame tick
  property p_strobe;
    @(posedge sys_clk_i) disable iff (!rst_n_i) frame_tick |=> sample_strobe_o;
  endproperty
  a_strobe: assert property (p_strobe) else $error("sample strobe missing"); // RULE_02

  // RULE_04 ratio 1: over-range in shows on flag after the fixed delay
  property p_ovr_set;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (over_a_i && sample_clock_divide_ratio_i == DIV_SEL_1 && !sys_pending)
      ##1 (sample_clock_divide_ratio_i == DIV_SEL_1 && !sys_pending)[*8]
      |=> overrange_flag_chan_a_o;
  endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("over-range flag late"); // RULE_04

  // RULE_05 channel b flag never drops while extension hold is running
  property p_ovr_hold;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (hold_b != '0 && overrange_flag_chan_b_o) |=> overrange_flag_chan_b_o;
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("over-range released early"); // RULE_05

  // RULE_03 reference marker comes only out of a running latency count
  property p_ref;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      ref_sample_o |-> $past(lat_busy) && $past(lat_cnt) == 8'h01;
  endproperty
  a_ref: assert property (p_ref) else $error("reference marker misplaced"); // RULE_03

  // RULE_08 countdown ends in a boundary
  property p_sys_end;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (sys_pending && sys_wait == 7'h01 && !sysref_rise) |=> lmfc_boundary_o && !sys_pending;
  endproperty
  a_sys_end: assert property (p_sys_end) else $error("countdown without boundary"); // RULE_08
endmodule

// ---- rtl/sample_timing_pkg.sv ----
package sample_timing_pkg;
  // divide ratio select codes: 1, 2, 4, 8
  localparam logic [1:0] DIV_SEL_1      = 2'h0;
  localparam logic [1:0] DIV_SEL_2      = 2'h1;
  localparam logic [1:0] DIV_SEL_4      = 2'h2;
  localparam logic [1:0] DIV_SEL_8      = 2'h3;
  localparam int         DIV_MAX        = 8;
  localparam int         DIV_CNT_W      = 3;
  // latencies in frame half cycles (fractional figures kept exact)
  localparam int         LAT_CORE_HALF  = 25;   // 12.5 frame cycles
  localparam int         OVR_ASSERT_HALF = 15;  // 7.5 frame cycles
  localparam int         OVR_EXT_MAX    = 15;   // release extension, frame cycles
  localparam int         OVR_EXT_W      = 4;
  // sysref to lmfc delay, input clock half cycles per divide setting
  localparam int         SYS_LMFC_HALF_1 = 7;   // 3.5 cycles
  localparam int         SYS_LMFC_HALF_2 = 16;  // 8 cycles
  localparam int         SYS_LMFC_HALF_4 = 30;  // 15 cycles
  localparam int         SYS_LMFC_HALF_8 = 58;  // 29 cycles
  localparam int         SYSREF_MIN_FRAMES = 2;
  // lmfc counter, frames per multiframe
  localparam int         LMFC_FRAMES    = 32;
  localparam int         LMFC_CNT_W     = 5;
endpackage

// ---- test/adc_sample_timing_ovr_sysref_tb.sv ----
`timescale 1ns/10ps
module adc_sample_timing_ovr_sysref_tb;
  import sample_timing_pkg::*;
  logic       sys_clk_i;
  logic       rst_n_i = 1'b0;
  logic [1:0] ratio   = 2'h0;
  logic [3:0] ext     = 4'h0;
  logic       fire    = 1'b0;
  logic       sysref;
  logic [1:0] over    = 2'h0;
  logic       strobe, bound, refs;
  logic [1:0] flag, flg_q, ovr_q;
  logic       sys_q;
  int         n_fail, checked, k;
  int         q_str[$], q_lmf[$], q_ref[$], q_rise[2][$], q_wid[2][$];
  int         c_str, c_sys, c_bnd, c_ovr[2], c_flg[2];

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  sample_timing_core DUT (
    .sys_clk_i                  (sys_clk_i),
    .rst_n_i                    (rst_n_i),
    .sample_clock_divide_ratio_i(ratio),
    .ovr_release_ext_i          (ext),
    .sysref_i                   (sysref),
    .over_a_i                   (over[0]),
    .over_b_i                   (over[1]),
    .sample_strobe_o            (strobe),
    .lmfc_boundary_o            (bound),
    .ref_sample_o               (refs),
    .overrange_flag_chan_a_o    (flag[0]),
    .overrange_flag_chan_b_o    (flag[1])
  );

  sysref_source SRC (
    .sys_clk_i(sys_clk_i),
    .ratio_i  (ratio),
    .fire_i   (fire),
    .sysref_o (sysref)
  );

  task automatic results();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic cmp(input int got, input int exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  function automatic int pend();
    return q_str.size() + q_lmf.size() + q_ref.size() + q_rise[0].size()
           + q_rise[1].size() + q_wid[0].size() + q_wid[1].size();
  endfunction

  // bounded wait for a condition sampled at falling edges
  task automatic wait_until(input bit on_bound);
    k = 0;
    while ((on_bound ? bound !== 1'b1 : pend() > 0) && k < 3000) begin
      @(negedge sys_clk_i);
      k++;
    end
    if (k == 3000) begin
      n_fail++;
      results();
    end
  endtask

  // ratio may only change under reset, so each setting starts fresh
  task automatic do_reset(input logic [1:0] r);
    rst_n_i = 1'b0;
    ratio = r;
    repeat (8) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    repeat (20) @(negedge sys_clk_i);
  endtask

  // count clock edges since each event; sysref and over-range rises reset their counts here
  always @(posedge sys_clk_i) begin
    c_str++;
    c_sys++;
    c_bnd++;
    if (sysref === 1'b1 && sys_q === 1'b0) c_sys = 0;
    sys_q = sysref;
    for (int i = 0; i < 2; i++) begin
      c_ovr[i]++;
      c_flg[i]++;
      if (over[i] && !ovr_q[i]) c_ovr[i] = 0;
    end
    ovr_q = over;
  end

  // outputs are settled at the falling edge; take the oldest note per event
  always @(negedge sys_clk_i) begin
    if (strobe === 1'b1) begin
      if (q_str.size() > 0) cmp(c_str, q_str.pop_front());
      c_str = 0;
    end
    if (bound === 1'b1) begin
      if (q_lmf.size() > 0) cmp(c_sys, q_lmf.pop_front());
      c_bnd = 0;
    end
    if (refs === 1'b1 && q_ref.size() > 0) cmp(c_bnd, q_ref.pop_front());
    for (int i = 0; i < 2; i++) begin
      if (flag[i] === 1'b1 && flg_q[i] === 1'b0) begin
        if (q_rise[i].size() > 0) cmp(c_ovr[i], q_rise[i].pop_front());
        c_flg[i] = 0;
      end
      if (flag[i] === 1'b0 && flg_q[i] === 1'b1 && q_wid[i].size() > 0)
        cmp(c_flg[i], q_wid[i].pop_front());
    end
    flg_q = flag;
  end

  // main sequence: every divide ratio with an alignment, then over-range runs
  initial begin
    int h;
    int n[2];
    n_fail = 0;
    checked = 0;
    void'($urandom(86));
    for (int r = 0; r < 4; r++) begin
      do_reset(r[1:0]);
      repeat (3) q_str.push_back(1 << r);
      wait_until(1'b0);
      h = (r == 0) ? SYS_LMFC_HALF_1 : (r == 1) ? SYS_LMFC_HALF_2 :
          (r == 2) ? SYS_LMFC_HALF_4 : SYS_LMFC_HALF_8;
      // fire just after a free boundary so the next one is far away
      wait_until(1'b1);
      repeat ($urandom_range(7, 1)) @(negedge sys_clk_i);
      // note only now, so the free boundary above cannot take it
      q_lmf.push_back((h + 1) / 2);
      fire <= 1'b1;
      @(negedge sys_clk_i);
      fire <= 1'b0;
      wait_until(1'b0);
      repeat (14 << r) @(negedge sys_clk_i);
      q_ref.push_back(13 << r);
      wait_until(1'b0);
    end
    do_reset(DIV_SEL_1);
    for (int t = 0; t < 4; t++) begin
      ext = (t == 0) ? 4'h0 : (t == 1) ? 4'hf : 4'($urandom_range(14, 1));
      for (int i = 0; i < 2; i++) begin
        n[i] = $urandom_range(4, 1);
        q_rise[i].push_back((OVR_ASSERT_HALF + 1) / 2);
        q_wid[i].push_back(n[i] + int'(ext));
      end
      for (int c = 0; c < 6; c++) begin
        over[0] = c < n[0];
        over[1] = c < n[1];
        @(negedge sys_clk_i);
      end
      wait_until(1'b0);
      repeat (30) @(negedge sys_clk_i);
    end
    results();
  end
endmodule

// ---- test/sysref_source.sv ----
`timescale 1ns/10ps
// sysref source: one pulse per request, changes only at falling edges
module sysref_source
  import sample_timing_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic [1:0] ratio_i,
  input  wire logic       fire_i,
  output logic            sysref_o
);
  int cnt = 0;
  // high, then low, two frames each
  always @(negedge sys_clk_i) begin
    if (fire_i === 1'b1 && cnt == 0) cnt = 2 * SYSREF_MIN_FRAMES << ratio_i;
    else if (cnt > 0) cnt = cnt - 1;
    sysref_o = cnt > (SYSREF_MIN_FRAMES << ratio_i);
  end
endmodule
